// ---- shared/citd_pkg.sv ----
// Purpose: shared constants and carriers for the instruction decoder and cycle sequencer
// Assumes: 14-bit instruction words, 8-bit file registers, 7-bit in-bank file address
// Notes: opcode values are fixed here and used by the core, its assertions and the testbench

package citd_pkg;

	// ----------------------------------------
	// word layout
	// ----------------------------------------
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int D_POS = 7;
	localparam int B_LSB = 7;
	localparam int OP6_LSB = 8;
	localparam int OP4_LSB = 10;
	localparam int OP3_LSB = 11;
	localparam int N_POS = 2;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int PHASES_PER_CYCLE = 4;
	localparam logic [1:0] LAST_PHASE = 2'(PHASES_PER_CYCLE - 1);
	localparam logic [6:0] FILE_ADDR_MAX = 7'h7F;
	localparam logic [6:0] IND_PORT0 = 7'h00;
	localparam logic [6:0] IND_PORT1 = 7'h01;
	localparam logic D_TO_ACC = 1'b0;

	// ----------------------------------------
	// opcodes, byte-oriented (bits 13:8)
	// ----------------------------------------
	localparam logic [5:0] OP_MOVE_W = 6'h00;
	localparam logic [5:0] OP_SUB = 6'h02;
	localparam logic [5:0] OP_DEC = 6'h03;
	localparam logic [5:0] OP_IOR = 6'h04;
	localparam logic [5:0] OP_AND = 6'h05;
	localparam logic [5:0] OP_XOR = 6'h06;
	localparam logic [5:0] OP_ADD = 6'h07;
	localparam logic [5:0] OP_MOVE_F = 6'h08;
	localparam logic [5:0] OP_COMP = 6'h09;
	localparam logic [5:0] OP_INC = 6'h0A;
	localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
	localparam logic [5:0] OP_SWAP = 6'h0E;
	localparam logic [5:0] OP_INC_SKIP = 6'h0F;
	localparam logic [5:0] OP_CLEAR = 6'h01;
	// ----------------------------------------
	// opcodes, bit-oriented (bits 13:10)
	// ----------------------------------------
	localparam logic [3:0] OP_BIT_CLR = 4'h4;
	localparam logic [3:0] OP_BIT_SET = 4'h5;
	localparam logic [3:0] OP_SKIP_CLR = 4'h6;
	localparam logic [3:0] OP_SKIP_SET = 4'h7;
	// ----------------------------------------
	// opcodes, literal and control
	// ----------------------------------------
	localparam logic [2:0] OP3_CALL = 3'h4;
	localparam logic [2:0] OP3_JUMP = 3'h5;
	localparam logic [5:0] OP_LOAD_LIT = 6'h30;
	localparam logic [5:0] OP_EXIT_LIT = 6'h34;
	localparam logic [4:0] OP5_REL_JUMP = 5'h19;
	localparam logic [13:0] W_SUB_EXIT = 14'h0008;
	localparam logic [13:0] W_INT_EXIT = 14'h0009;
	localparam logic [13:0] W_CALL_ACC = 14'h000A;
	localparam logic [13:0] W_JUMP_ACC = 14'h000B;
	localparam logic [13:0] W_IND_MASK = 14'h3FF0;
	localparam logic [13:0] W_IND_BASE = 14'h0010;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef enum logic [2:0] {
		CLS_BYTE = 3'b001,
		CLS_BIT = 3'b010,
		CLS_LIT = 3'b100
	} citd_class_t;

	typedef enum logic [3:0] {
		FL_NONE = 4'h0,
		FL_ABS_JUMP = 4'h1,
		FL_CALL = 4'h2,
		FL_CALL_ACC = 4'h3,
		FL_SUB_EXIT = 4'h4,
		FL_EXIT_LIT = 4'h5,
		FL_INT_EXIT = 4'h6,
		FL_REL_JUMP = 4'h7,
		FL_ACC_JUMP = 4'h8,
		FL_SKIP = 4'h9
	} citd_flow_t;

	typedef struct packed {
		citd_class_t cls;
		logic [5:0] opc;
		logic dest_f;
		logic [6:0] faddr;
		logic [2:0] bit_idx;
		logic [7:0] lit8;
		logic [10:0] lit11;
		logic ptr_sel;
		logic [1:0] auto_step_style;
		logic indirect_op;
	} citd_dec_t;

	typedef struct packed {
		logic valid;
		citd_flow_t kind;
		logic [10:0] target;
	} citd_flow_evt_t;

endpackage

// ---- design/citd_phase_gen.sv ----
// Purpose: splits the oscillator clock into the four phases of an instruction cycle
// Assumes: one clock, synchronous active-low reset
// Notes: phases are one-hot enables, phase 3 marks the cycle boundary

`timescale 1ns/1ps
`default_nettype none

module citd_phase_gen (
	input wire logic clk_i, // oscillator clock
	input wire logic rst_n_i, // synchronous reset, active low
	output logic [3:0] phase_o // one-hot phase enable
);
	import citd_pkg::*;

	logic [1:0] cnt;
	logic [1:0] next_cnt;

	always_comb begin
		next_cnt = (cnt == LAST_PHASE) ? 2'h0 : 2'(cnt + 2'h1);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt <= 2'h0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign phase_o = 4'(4'h1 << cnt);

endmodule

`default_nettype wire

// ---- design/citd_core.sv ----
// Purpose: instruction word decoder and instruction cycle sequencer of the core
// Assumes: pointer-location flags and file read data come in synchronous to CLK_I
// Notes: file data must be valid in the phase after the read strobe
//
// Overview of operation
// - each instruction is a single 14-bit word holding opcode and all operands.
// - opcodes fall into byte-oriented, bit-oriented and literal-and-control groups.
// - an instruction not listed as an exception takes one instruction cycle.
// - direct and accumulator-computed subroutine jumps take two cycles.
// - subroutine exit, exit with literal and interrupt exit take two cycles.
// - jumps, taken bit skips and skip-if-zero count operations with a zero result take two cycles.
// - an indirect access while the pointer addresses program memory adds one cycle.
// - one instruction cycle is four oscillator clocks.
// - a named file register is always read, then modified; only d=1 byte words and bit set/clear store it.
// - destination bit 0 sends the result to the accumulator, 1 to the file register.
// - the file address field covers 0x00 to 0x7F of the current bank.
// - the bit index field picks one bit of an 8-bit file register.
// - indirect operations carry one bit choosing pointer 0 or pointer 1.
// - indirect operations carry a two-bit pre/post increment/decrement style.

`timescale 1ns/1ps
`default_nettype none

module citd_core (
	input wire logic CLK_I, // oscillator clock, 50 MHz
	input wire logic RST_N_I, // synchronous reset, active low
	input wire logic [13:0] INSTR_I, // fetched instruction word
	input wire logic INSTR_VALID_I, // word on INSTR_I is valid
	output logic INSTR_READY_O, // word taken at this edge
	input wire logic [1:0] PTR_IN_PROG_I, // pointer n addresses program memory
	input wire logic [7:0] ACC_I, // accumulator value
	input wire logic [7:0] FILE_RDATA_I, // file read data, phase after strobe
	output logic [6:0] FILE_ADDR_O, // file register address
	output logic FILE_RD_O, // file read strobe
	output logic FILE_WR_O, // file write strobe
	output logic [7:0] FILE_WDATA_O, // file write data
	output logic ACC_WR_O, // accumulator write strobe
	output logic [7:0] ACC_WDATA_O, // accumulator write data
	output citd_pkg::citd_dec_t DEC_O, // decoded fields of current word
	output citd_pkg::citd_flow_evt_t FLOW_O, // program flow event, one clock
	output logic BUSY_O // an instruction is executing
);
	import citd_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_STALL = 3'b100
	} citd_state_t;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic citd_dec_t decode(input logic [13:0] w);
		citd_dec_t r;
		r.opc = w[13:OP6_LSB];
		r.dest_f = w[D_POS];
		r.faddr = w[FADDR_W-1:0] & FILE_ADDR_MAX;
		r.bit_idx = w[B_LSB+2:B_LSB];
		r.lit8 = w[7:0];
		r.lit11 = w[10:0];
		r.ptr_sel = w[N_POS];
		r.auto_step_style = w[1:0];
		r.indirect_op = (w & W_IND_MASK) == W_IND_BASE;
		if (w[13:12] == 2'b00) begin
			r.cls = CLS_BYTE;
		end else if (w[13:12] == 2'b01) begin
			r.cls = CLS_BIT;
		end else begin
			r.cls = CLS_LIT;
		end
		if (w[13:8] == 6'h00) begin
			r.cls = CLS_LIT; // control words share the zero opcode
		end
		if (w[13:8] == OP_MOVE_W && w[D_POS]) begin
			r.cls = CLS_BYTE;
		end
		return r;
	endfunction

	function automatic citd_flow_t flow_kind(input logic [13:0] w);
		citd_flow_t k;
		k = FL_NONE;
		if (w[13:OP3_LSB] == OP3_CALL) begin
			k = FL_CALL;
		end else if (w[13:OP3_LSB] == OP3_JUMP) begin
			k = FL_ABS_JUMP;
		end else if (w[13:9] == OP5_REL_JUMP) begin
			k = FL_REL_JUMP;
		end else if (w[13:10] == OP_EXIT_LIT[5:2]) begin
			k = FL_EXIT_LIT; // low opcode bits are don't-care
		end else if (w == W_SUB_EXIT) begin
			k = FL_SUB_EXIT;
		end else if (w == W_INT_EXIT) begin
			k = FL_INT_EXIT;
		end else if (w == W_CALL_ACC) begin
			k = FL_CALL_ACC;
		end else if (w == W_JUMP_ACC) begin
			k = FL_ACC_JUMP;
		end
		return k;
	endfunction

	function automatic logic [7:0] modify(input logic [5:0] op, input logic [7:0] f,
			input logic [7:0] w);
		logic [7:0] r;
		r = f;
		case (op)
			OP_MOVE_W: r = w;
			OP_CLEAR: r = 8'h00;
			OP_SUB: r = 8'(f - w);
			OP_DEC, OP_DEC_SKIP: r = 8'(f - 8'h01);
			OP_INC, OP_INC_SKIP: r = 8'(f + 8'h01);
			OP_IOR: r = f | w;
			OP_AND: r = f & w;
			OP_XOR: r = f ^ w;
			OP_ADD: r = 8'(f + w);
			OP_COMP: r = ~f;
			OP_SWAP: r = {f[3:0], f[7:4]};
			default: r = f;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [3:0] phase;
	citd_state_t state, next_state;
	logic [13:0] word, next_word;
	citd_dec_t dec, next_dec;
	citd_flow_t kind, next_kind;
	logic [1:0] left, next_left;
	logic [7:0] res, next_res;
	logic res_to_file, next_res_to_file;
	logic res_to_acc, next_res_to_acc;
	citd_flow_evt_t flow, next_flow;
	logic boundary;
	logic uses_file;
	logic skip_taken;
	logic [1:0] extra;
	logic ind_hit;
	citd_dec_t in_dec;
	citd_flow_t in_kind;

	citd_phase_gen u_phase (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.phase_o(phase)
	);

	assign boundary = phase[3];
	assign INSTR_READY_O = boundary && (state == ST_IDLE || left == 2'h0);
	assign in_dec = decode(INSTR_I);
	assign in_kind = flow_kind(INSTR_I);
	// file operand for both file groups, even when the word only writes it
	assign uses_file = (dec.cls == CLS_BYTE) || (dec.cls == CLS_BIT);

	// ----------------------------------------
	// cycle count of the incoming word
	// ----------------------------------------
	always_comb begin
		logic two;
		two = (in_kind != FL_NONE);
		ind_hit = 1'b0;
		if (in_dec.indirect_op) begin
			ind_hit = PTR_IN_PROG_I[in_dec.ptr_sel];
		end else if (in_dec.cls != CLS_LIT &&
				(in_dec.faddr == IND_PORT0 || in_dec.faddr == IND_PORT1)) begin
			ind_hit = PTR_IN_PROG_I[in_dec.faddr[0]];
		end
		extra = 2'({1'b0, two} + {1'b0, ind_hit});
	end

	// ----------------------------------------
	// modify stage and skip test
	// ----------------------------------------
	always_comb begin
		logic [7:0] m;
		m = modify(dec.opc, FILE_RDATA_I, ACC_I);
		skip_taken = 1'b0;
		if (dec.cls == CLS_BIT) begin
			m = FILE_RDATA_I;
			if (word[13:OP4_LSB] == OP_BIT_CLR) begin
				m[dec.bit_idx] = 1'b0;
			end else if (word[13:OP4_LSB] == OP_BIT_SET) begin
				m[dec.bit_idx] = 1'b1;
			end else if (word[13:OP4_LSB] == OP_SKIP_CLR) begin
				skip_taken = !FILE_RDATA_I[dec.bit_idx];
			end else begin
				skip_taken = FILE_RDATA_I[dec.bit_idx];
			end
		end else if (dec.opc == OP_DEC_SKIP || dec.opc == OP_INC_SKIP) begin
			skip_taken = (m == 8'h00);
		end
		next_res = (phase[2] && state == ST_EXEC) ? m : res;
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_word = word;
		next_dec = dec;
		next_kind = kind;
		next_left = left;
		next_res_to_file = res_to_file;
		next_res_to_acc = res_to_acc;
		next_flow = '{valid: 1'b0, kind: FL_NONE, target: 11'h000};
		if (state == ST_EXEC && phase[2]) begin
			next_res_to_acc = 1'b0;
			next_res_to_file = 1'b0;
			if (dec.cls == CLS_BYTE) begin
				if (dec.dest_f == D_TO_ACC) begin
					next_res_to_acc = 1'b1;
				end else begin
					next_res_to_file = 1'b1;
				end
			end else if (dec.cls == CLS_BIT) begin
				next_res_to_file = (word[13:OP4_LSB] == OP_BIT_CLR) ||
					(word[13:OP4_LSB] == OP_BIT_SET);
			end
			if (skip_taken) begin
				next_left = 2'(left + 2'h1);
				next_kind = FL_SKIP;
			end
		end
		if (state == ST_EXEC && boundary && kind != FL_NONE) begin
			next_flow = '{valid: 1'b1, kind: kind, target: dec.lit11};
		end
		if (boundary) begin
			if (INSTR_READY_O) begin
				if (INSTR_VALID_I) begin
					next_state = ST_EXEC;
					next_word = INSTR_I;
					next_dec = in_dec;
					next_kind = in_kind;
					next_left = extra;
				end else begin
					next_state = ST_IDLE;
				end
			end else begin
				next_state = ST_STALL;
				next_left = 2'(left - 2'h1);
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state <= ST_IDLE;
			word <= 14'h0000;
			dec <= '0;
			kind <= FL_NONE;
			left <= 2'h0;
			res <= 8'h00;
			res_to_file <= 1'b0;
			res_to_acc <= 1'b0;
			flow <= '0;
		end else begin
			state <= next_state;
			word <= next_word;
			dec <= next_dec;
			kind <= next_kind;
			left <= next_left;
			res <= next_res;
			res_to_file <= next_res_to_file;
			res_to_acc <= next_res_to_acc;
			flow <= next_flow;
		end
	end

	// ----------------------------------------
	// strobes: read in phase 1, store in phase 3
	// ----------------------------------------
	// literal loads bypass the modify stage, so W is written straight from the word
	logic lit_load;
	assign lit_load = dec.cls == CLS_LIT &&
		(dec.opc == OP_LOAD_LIT || kind == FL_EXIT_LIT);
	assign FILE_ADDR_O = dec.faddr;
	assign FILE_RD_O = (state == ST_EXEC) && phase[1] && uses_file;
	assign FILE_WR_O = (state == ST_EXEC) && phase[3] && res_to_file;
	assign FILE_WDATA_O = res;
	assign ACC_WR_O = (state == ST_EXEC) && phase[3] && (res_to_acc || lit_load);
	assign ACC_WDATA_O = lit_load ? dec.lit8 : res;
	assign DEC_O = dec;
	assign FLOW_O = flow;
	assign BUSY_O = state != ST_IDLE;

endmodule

`default_nettype wire

// ---- tb/citd_core_assertions.sv ----
// Purpose: port checks for citd_core
// Assumes: bound to every citd_core instance
// Notes: a take is ready and valid at one edge
`timescale 1ns/1ps
`default_nettype none
module citd_core_assertions
	import citd_pkg::*;
(
	input wire logic CLK_I, // clock
	input wire logic RST_N_I, // reset, active low
	input wire logic [13:0] INSTR_I, // word
	input wire logic INSTR_VALID_I, // word valid
	input wire logic INSTR_READY_O, // take edge
	input wire logic [1:0] PTR_IN_PROG_I, // pointer in program memory
	input wire logic [6:0] FILE_ADDR_O, // file address
	input wire logic FILE_RD_O, // read strobe
	input wire logic FILE_WR_O, // write strobe
	input wire logic ACC_WR_O, // accumulator strobe
	input wire citd_dec_t DEC_O, // decoded fields
	input wire citd_flow_evt_t FLOW_O // flow event
);
	wire tk = INSTR_READY_O && INSTR_VALID_I;
	wire [5:0] op = INSTR_I[13:8];
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// ----------------------------------------
	// two-cycle span: seven blocked edges, then ready
	// ----------------------------------------
	sequence s_hold7;
		!INSTR_READY_O [*7] ##1 INSTR_READY_O;
	endsequence
	chk_phase_gap: assert property (INSTR_READY_O |=> !INSTR_READY_O [*3])
		else $error("ready closer than four clocks");
	chk_one_cycle: assert property (tk && op == OP_ADD && INSTR_I[6:1] != 6'h00
		|-> ##4 INSTR_READY_O)
		else $error("one-cycle word not done in four clocks");
	chk_call_flow: assert property (tk && INSTR_I[13:11] == OP3_CALL |-> ##5
		FLOW_O.valid && FLOW_O.kind == FL_CALL && FLOW_O.target == $past(INSTR_I[10:0], 5))
		else $error("call event wrong");
	chk_exit_span: assert property (tk && INSTR_I == W_SUB_EXIT |=> s_hold7)
		else $error("subroutine exit not two cycles");
	chk_jump_span: assert property (tk && INSTR_I[13:11] == OP3_JUMP |=> s_hold7)
		else $error("jump not two cycles");
	chk_ind_extra: assert property (tk && (INSTR_I & W_IND_MASK) == W_IND_BASE
		&& PTR_IN_PROG_I[INSTR_I[N_POS]] |=> s_hold7)
		else $error("indirect extra cycle missing");
	chk_rmw_read: assert property (tk && (op == OP_ADD || op == OP_CLEAR)
		|-> ##2 FILE_RD_O && FILE_ADDR_O == $past(INSTR_I[6:0], 2))
		else $error("file read missing or wrong address");
	chk_dest_sel: assert property (tk && op == OP_ADD |-> ##4
		FILE_WR_O == $past(INSTR_I[D_POS], 4) && ACC_WR_O != $past(INSTR_I[D_POS], 4))
		else $error("result sent to wrong target");
	chk_bit_field: assert property (tk && INSTR_I[13:12] == 2'h1 |=>
		DEC_O.cls == CLS_BIT && DEC_O.bit_idx == $past(INSTR_I[9:7]))
		else $error("bit word decoded wrongly");
	chk_ind_fields: assert property (tk && (INSTR_I & W_IND_MASK) == W_IND_BASE |=>
		DEC_O.ptr_sel == $past(INSTR_I[N_POS]) && DEC_O.auto_step_style == $past(INSTR_I[1:0]))
		else $error("indirect fields decoded wrongly");
endmodule
bind citd_core citd_core_assertions u_chk (.CLK_I, .RST_N_I, .INSTR_I, .INSTR_VALID_I,
	.INSTR_READY_O, .PTR_IN_PROG_I, .FILE_ADDR_O, .FILE_RD_O, .FILE_WR_O, .ACC_WR_O,
	.DEC_O, .FLOW_O);
`default_nettype wire

// ---- tb/citd_file_model.sv ----
// Purpose: file register space behind citd_core
// Assumes: read data due one clock after the read strobe
// Notes: a location a holds {a, 1} at start
`timescale 1ns/1ps
`default_nettype none
module citd_file_model (
	input wire logic clk_i, // clock
	input wire logic rd_i, // read strobe
	input wire logic wr_i, // write strobe
	input wire logic [6:0] addr_i, // address
	input wire logic [7:0] wdata_i, // write data
	output logic [7:0] rdata_o // read data
);
	logic [7:0] mem [128];
	initial begin
		rdata_o = 8'h00;
		for (int a = 0; a < 128; a++) mem[a] = {a[6:0], 1'b1};
	end
	// stale data flips each clock so a late sample cannot pass
	always @(posedge clk_i) begin
		rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
		if (wr_i) mem[addr_i] <= wdata_i;
	end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for citd_core
// Assumes: 50 MHz clock, file model answers one clock after the strobe
// Notes: span counts edges from a take to the next ready edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import citd_pkg::*;
	logic clk = 0, rst_n = 0, vld = 0, rd, wr, rdy, awr, busy, fw, aw, rs;
	logic [13:0] ins = '0;
	logic [1:0] ptr = '0;
	logic [7:0] acc = 8'h11, rdat, wdat, awd, fwd, asd, span;
	logic [6:0] fa;
	citd_dec_t dec;
	citd_flow_evt_t flow;
	citd_flow_t fk;
	logic [10:0] ft;
	logic [1:0] bb;
	int err_count = 0, num_checks = 0;
	initial forever #10 clk = ~clk;
	citd_core dut (.CLK_I(clk), .RST_N_I(rst_n), .INSTR_I(ins), .INSTR_VALID_I(vld),
		.INSTR_READY_O(rdy), .PTR_IN_PROG_I(ptr), .ACC_I(acc), .FILE_RDATA_I(rdat),
		.FILE_ADDR_O(fa), .FILE_RD_O(rd), .FILE_WR_O(wr), .FILE_WDATA_O(wdat),
		.ACC_WR_O(awr), .ACC_WDATA_O(awd), .DEC_O(dec), .FLOW_O(flow), .BUSY_O(busy));
	citd_file_model u_mem (.clk_i(clk), .rd_i(rd), .wr_i(wr), .addr_i(fa),
		.wdata_i(wdat), .rdata_o(rdat));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] mem0(input logic [6:0] a);
		return {a, 1'b1};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic run(input logic [13:0] w, input logic [1:0] p);
		int i;
		ins <= w;
		ptr <= p;
		vld <= 1'b1;
		bb = 2'h1;
		for (i = 0; i < 12; i++) begin
			@(posedge clk);
			if (rdy === 1'b1) begin
				bb[0] = busy;
				break;
			end
		end
		vld <= 1'b0;
		{fw, aw, rs} = 3'h0;
		fk = FL_NONE;
		ft = 11'h000;
		for (i = 1; i < 16; i++) begin
			@(posedge clk);
			if (rd === 1'b1) rs = 1'b1;
			if (wr === 1'b1) {fw, fwd} = {1'b1, wdat};
			if (awr === 1'b1) {aw, asd} = {1'b1, awd};
			if (flow.valid === 1'b1) begin
				fk = flow.kind;
				ft = flow.target;
			end
			if (rdy === 1'b1) begin
				bb[1] = busy;
				break;
			end
		end
		span = 8'(i);
		// idle at the take edge, busy at the finishing edge
		chk({6'h00, bb}, 8'h02);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_span();
		logic [13:0] w [15] = '{{OP3_CALL, 11'h123}, W_CALL_ACC, W_SUB_EXIT,
			{OP_EXIT_LIT, 8'h3C}, W_INT_EXIT, {OP3_JUMP, 11'h055}, {OP5_REL_JUMP, 9'h0AA},
			W_JUMP_ACC, {OP_DEC_SKIP, 8'h00}, {OP_INC_SKIP, 8'h7F}, {OP_SKIP_SET, 10'h030},
			{OP_SKIP_CLR, 10'h030}, W_IND_BASE | 14'h0005, W_IND_BASE | 14'h0005,
			{OP_DEC_SKIP, 8'h30}};
		logic [1:0] p [15] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 1, 0};
		logic [7:0] c [15] = '{8, 8, 8, 8, 8, 8, 8, 8, 8, 8, 8, 4, 8, 4, 4};
		citd_flow_t k [15] = '{FL_CALL, FL_CALL_ACC, FL_SUB_EXIT, FL_EXIT_LIT, FL_INT_EXIT,
			FL_ABS_JUMP, FL_REL_JUMP, FL_ACC_JUMP, FL_SKIP, FL_SKIP, FL_SKIP, FL_NONE, FL_NONE,
			FL_NONE, FL_NONE};
		for (int i = 0; i < 15; i++) begin
			run(w[i], p[i]);
			chk(span, c[i]);
			chk({4'h0, fk}, {4'h0, k[i]});
			if (k[i] != FL_NONE) begin
				chk({5'h00, ft[10:8]}, {5'h00, w[i][10:8]});
				chk(ft[7:0], w[i][7:0]);
			end
		end
	endtask
	task automatic t_byte();
		run({OP_ADD, 1'b1, 7'h7F}, 2'h0);
		chk(span, 8'h04);
		chk({6'h00, fw, aw}, 8'h02);
		chk(fwd, mem0(7'h7F) + acc);
		run({OP_ADD, 1'b0, 7'h00}, 2'h0);
		chk({6'h00, fw, aw}, 8'h01);
		chk(asd, mem0(7'h00) + acc);
		run({OP_CLEAR, 1'b1, 7'h05}, 2'h0);
		chk({6'h00, rs, fw}, 8'h03);
		chk(fwd, 8'h00);
	endtask
	task automatic t_bits();
		run({OP_BIT_SET, 3'h2, 7'h11}, 2'h0);
		chk(fwd, mem0(7'h11) | 8'h04);
		run({OP_BIT_CLR, 3'h0, 7'h12}, 2'h0);
		chk(fwd, mem0(7'h12) & 8'hFE);
	endtask
	// location 0x20 holds 0x41 and the accumulator 0x11 throughout
	task automatic t_ops();
		logic [13:0] w [11] = '{{OP_MOVE_F, 8'h20}, {OP_SUB, 8'h20}, {OP_DEC, 8'h20},
			{OP_IOR, 8'h20}, {OP_AND, 8'h20}, {OP_XOR, 8'h20}, {OP_COMP, 8'h20},
			{OP_INC, 8'h20}, {OP_SWAP, 8'h20}, {OP_LOAD_LIT, 8'hA5},
			{OP_EXIT_LIT[5:2], 2'h3, 8'h5A}};
		logic [7:0] e [11] = '{8'h41, 8'h30, 8'h40, 8'h51, 8'h01, 8'h50, 8'hBE, 8'h42,
			8'h14, 8'hA5, 8'h5A};
		for (int i = 0; i < 11; i++) begin
			run(w[i], 2'h0);
			chk({6'h00, fw, aw}, 8'h01);
			chk(asd, e[i]);
		end
		run({OP_MOVE_W, 1'b1, 7'h21}, 2'h0);
		chk({6'h00, fw, aw}, 8'h02);
		chk(fwd, acc);
		run(W_IND_BASE | 14'h0006, 2'h0);
		chk({3'h0, dec.indirect_op, dec.ptr_sel, 1'b0, dec.auto_step_style}, 8'h1A);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------
	// main and watchdog
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_span();
		t_byte();
		t_bits();
		t_ops();
		end_sim();
	end
	// runs need about 330 clocks; the limit leaves a wide margin
	initial begin
		#40000;
		err_count++;
		end_sim();
	end
endmodule
`default_nettype wire
